// file: src/plsc_cfg_regs.sv
// plsc_cfg_regs: link control, link status, slot capability and interrupt registers
// assumes link training logic on the same clock and two strap pins stable around reset
`timescale 1ns/1ps
module plsc_cfg_regs (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic reverse_strap,
    input wire logic hotplug_strap,
    input wire logic link_training,
    input wire logic link_train_error,
    input wire logic [5:0] link_width,
    output logic [1:0] aspm_control,
    output logic link_disable,
    output logic retrain_link,
    output logic common_clock,
    output logic extended_sync,
    output logic reverse_mode,
    output logic hotplug_enabled,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // bus front end

    plsc_acc_if acc ();

    plsc_ahb_slave u_slave (
        .clock(clock),
        .reset_n(reset_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .acc(acc)
    );

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    wire wr_link = acc.wr_en && hit(acc.wr_addr, plsc_pkg::OFS_LINK);
    wire wr_stat = acc.wr_en && hit(acc.wr_addr, plsc_pkg::OFS_IRQ_STAT);
    wire wr_mask = acc.wr_en && hit(acc.wr_addr, plsc_pkg::OFS_IRQ_MASK);
    wire rd_link = acc.rd_en && hit(acc.rd_addr, plsc_pkg::OFS_LINK);
    wire rd_slot = acc.rd_en && hit(acc.rd_addr, plsc_pkg::OFS_SLOT);
    wire rd_stat = acc.rd_en && hit(acc.rd_addr, plsc_pkg::OFS_IRQ_STAT);
    wire rd_mask = acc.rd_en && hit(acc.rd_addr, plsc_pkg::OFS_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////////////
    // strap capture: pins synchronised, then held from shortly after reset

    logic rev_meta;
    logic rev_sync;
    logic hp_meta;
    logic hp_sync;
    logic [1:0] strap_cnt;
    logic hp_strap;

    always_ff @(posedge clock) begin
        rev_meta <= reverse_strap;
        rev_sync <= rev_meta;
        hp_meta <= hotplug_strap;
        hp_sync <= hp_meta;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            strap_cnt <= '0;
            reverse_mode <= 1'b0;
            hp_strap <= 1'b0;
        end else if (strap_cnt != plsc_pkg::STRAP_SETTLE) begin
            strap_cnt <= strap_cnt + 2'h1;
            reverse_mode <= rev_sync;
            hp_strap <= hp_sync;
        end
    end

    assign hotplug_enabled = hp_strap && reverse_mode;

    ////////////////////////////////////////////////////////////////////////////////
    // link control

    plsc_pkg::plsc_aspm_t aspm;
    assign aspm_control = aspm;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            aspm <= plsc_pkg::PLSC_ASPM_OFF;
            common_clock <= 1'b0;
            extended_sync <= 1'b0;
        end else if (wr_link) begin
            aspm <= plsc_pkg::plsc_aspm_t'(acc.wdata[plsc_pkg::ASPM_HI:plsc_pkg::ASPM_LO]);
            common_clock <= acc.wdata[plsc_pkg::CCLK_BIT];
            extended_sync <= acc.wdata[plsc_pkg::ESYNC_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            link_disable <= 1'b0;
            retrain_link <= 1'b0;
        end else if (wr_link && reverse_mode) begin
            link_disable <= acc.wdata[plsc_pkg::LDIS_BIT];
            retrain_link <= acc.wdata[plsc_pkg::RETRAIN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link status, sampled from training logic

    logic training;
    logic train_err;
    logic [5:0] width;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            training <= 1'b0;
            train_err <= 1'b0;
            width <= plsc_pkg::WIDTH_RST;
        end else begin
            training <= link_training;
            train_err <= link_train_error;
            width <= link_width;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky status, write one to clear, set wins

    logic [plsc_pkg::IRQ_W-1:0] irq_stat;
    logic [plsc_pkg::IRQ_W-1:0] irq_mask;
    logic [plsc_pkg::IRQ_W-1:0] events;
    logic [plsc_pkg::IRQ_W-1:0] clr;
    logic [plsc_pkg::IRQ_W-1:0] next_irq_stat;

    always_comb begin
        events = '0;
        events[plsc_pkg::IRQ_TRAIN_DONE] = training && !link_training;
        events[plsc_pkg::IRQ_TRAIN_ERR] = link_train_error && !train_err;
        events[plsc_pkg::IRQ_WIDTH] = link_width != width;
    end

    assign clr = wr_stat ? acc.wdata[plsc_pkg::IRQ_W-1:0] : '0;
    assign next_irq_stat = (irq_stat & ~clr) | events;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            irq_stat <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            if (wr_mask) begin
                irq_mask <= acc.wdata[plsc_pkg::IRQ_W-1:0];
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read words; unlisted bits stay zero

    logic [31:0] link_word;
    logic [31:0] slot_word;

    always_comb begin
        link_word = '0;
        link_word[plsc_pkg::ASPM_HI:plsc_pkg::ASPM_LO] = aspm;
        link_word[plsc_pkg::RCB_BIT] = 1'b0;
        link_word[plsc_pkg::LDIS_BIT] = link_disable;
        link_word[plsc_pkg::RETRAIN_BIT] = retrain_link;
        link_word[plsc_pkg::CCLK_BIT] = common_clock;
        link_word[plsc_pkg::ESYNC_BIT] = extended_sync;
        link_word[plsc_pkg::SPEED_HI:plsc_pkg::SPEED_LO] = plsc_pkg::SPEED_2G5;
        link_word[plsc_pkg::WIDTH_HI:plsc_pkg::WIDTH_LO] = width;
        link_word[plsc_pkg::TERR_BIT] = train_err;
        link_word[plsc_pkg::TRAIN_BIT] = training;
        link_word[plsc_pkg::SCLK_BIT] = plsc_pkg::SCLK_RST;
    end

    always_comb begin
        slot_word = '0;
        slot_word[plsc_pkg::ABP_BIT] = hotplug_enabled;
        slot_word[plsc_pkg::MRLP_BIT] = hotplug_enabled;
        slot_word[plsc_pkg::AIP_BIT] = hotplug_enabled;
        slot_word[plsc_pkg::PIP_BIT] = hotplug_enabled;
        slot_word[plsc_pkg::HPC_BIT] = hotplug_enabled;
    end

    assign acc.rdata = rd_link ? link_word :
                       rd_slot ? slot_word :
                       rd_stat ? {{(32-plsc_pkg::IRQ_W){1'b0}}, irq_stat} :
                       rd_mask ? {{(32-plsc_pkg::IRQ_W){1'b0}}, irq_mask} : '0;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    property p_aspm_write;
        @(posedge clock) disable iff (!reset_n)
        wr_link |=> aspm_control == $past(acc.wdata[plsc_pkg::ASPM_HI:plsc_pkg::ASPM_LO]);
    endproperty
    a_aspm_write: assert property (p_aspm_write)
        else $error("power management field did not take written value");

    property p_aspm_hold;
        @(posedge clock) disable iff (!reset_n)
        !wr_link |=> $stable(aspm_control);
    endproperty
    a_aspm_hold: assert property (p_aspm_hold)
        else $error("power management field changed without a write");

    property p_rcb_zero;
        @(posedge clock) disable iff (!reset_n)
        rd_link |-> acc.rdata[plsc_pkg::RCB_BIT] == 1'b0;
    endproperty
    a_rcb_zero: assert property (p_rcb_zero)
        else $error("completion boundary bit read as one");

    property p_fwd_locked;
        @(posedge clock) disable iff (!reset_n)
        wr_link && !reverse_mode |=> $stable(link_disable) && $stable(retrain_link);
    endproperty
    a_fwd_locked: assert property (p_fwd_locked)
        else $error("link disable or retrain changed in forward mode");

    property p_rev_write;
        @(posedge clock) disable iff (!reset_n)
        wr_link && reverse_mode |=>
            link_disable == $past(acc.wdata[plsc_pkg::LDIS_BIT]) &&
            retrain_link == $past(acc.wdata[plsc_pkg::RETRAIN_BIT]);
    endproperty
    a_rev_write: assert property (p_rev_write)
        else $error("link disable or retrain missed a reverse-mode write");

    property p_speed;
        @(posedge clock) disable iff (!reset_n)
        rd_link |-> acc.rdata[plsc_pkg::SPEED_HI:plsc_pkg::SPEED_LO] == plsc_pkg::SPEED_2G5;
    endproperty
    a_speed: assert property (p_speed)
        else $error("link speed field not one");

    property p_slot_caps;
        @(posedge clock) disable iff (!reset_n)
        rd_slot |-> acc.rdata[plsc_pkg::HPC_BIT] == (hp_strap && reverse_mode) &&
                    acc.rdata[plsc_pkg::ABP_BIT] == acc.rdata[plsc_pkg::HPC_BIT];
    endproperty
    a_slot_caps: assert property (p_slot_caps)
        else $error("slot capability bits disagree with hot-plug strap");

    property p_reserved;
        @(posedge clock) disable iff (!reset_n)
        rd_link |-> acc.rdata[31:29] == 3'h0 && acc.rdata[15:8] == 8'h00 &&
                    acc.rdata[2] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved link bits read nonzero");

    property p_set_wins;
        @(posedge clock) disable iff (!reset_n)
        events[plsc_pkg::IRQ_TRAIN_ERR] |=> irq_stat[plsc_pkg::IRQ_TRAIN_ERR] ##1 1'b1;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("training error event lost");

    property p_ctl_reset;
        @(posedge clock)
        !reset_n |=> aspm_control == plsc_pkg::PLSC_ASPM_OFF && !link_disable && !retrain_link;
    endproperty
    a_ctl_reset: assert property (p_ctl_reset)
        else $error("link controls not cleared by reset");

    property p_strap_hold;
        @(posedge clock) disable iff (!reset_n)
        strap_cnt == plsc_pkg::STRAP_SETTLE |=> $stable(reverse_mode) && $stable(hp_strap);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("captured straps changed after capture");

    property p_events_set;
        @(posedge clock) disable iff (!reset_n)
        events != '0 |=> (irq_stat & $past(events)) == $past(events);
    endproperty
    a_events_set: assert property (p_events_set)
        else $error("interrupt event lost against a clear");

    property p_irq_on;
        @(posedge clock) disable iff (!reset_n)
        (irq_stat & irq_mask) != '0 |=> irq;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("interrupt low with an unmasked status bit set");

    property p_irq_off;
        @(posedge clock) disable iff (!reset_n)
        (irq_stat & irq_mask) == '0 |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt high with no unmasked status bit set");

endmodule

// file: src/plsc_pkg.sv
// plsc_pkg: offsets, field positions and reset values of the link and slot config registers
// assumes a word-wide register bus decoded on the low address byte
// Function
// - two-bit power management control at bits 1:0, 00 off to 11 both, resets 00
// - read completion boundary bit 3 is read-only and always reads zero
// - link disable bit 4 and retrain bit 5 writable only in reverse mode; reset zero
// - negotiated link speed bits 19:16 read-only, value one, also at reset
// - slot capability bits 0,2,3,4,6 read one only with reverse-mode hot-plug strap
package plsc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_LINK = 8'hC0;
    localparam logic [7:0] OFS_SLOT = 8'hC4;
    localparam logic [7:0] OFS_IRQ_STAT = 8'hE0;
    localparam logic [7:0] OFS_IRQ_MASK = 8'hE4;

    ////////////////////////////////////////////////////////////////////////////////
    // link control and status fields
    localparam int ASPM_LO = 0;
    localparam int ASPM_HI = 1;
    localparam int RCB_BIT = 3;
    localparam int LDIS_BIT = 4;
    localparam int RETRAIN_BIT = 5;
    localparam int CCLK_BIT = 6;
    localparam int ESYNC_BIT = 7;
    localparam int SPEED_LO = 16;
    localparam int SPEED_HI = 19;
    localparam int WIDTH_LO = 20;
    localparam int WIDTH_HI = 25;
    localparam int TERR_BIT = 26;
    localparam int TRAIN_BIT = 27;
    localparam int SCLK_BIT = 28;
    localparam logic [3:0] SPEED_2G5 = 4'h1;
    localparam logic [5:0] WIDTH_RST = 6'h01;
    localparam logic SCLK_RST = 1'b1;

    typedef enum logic [1:0] {
        PLSC_ASPM_OFF = 2'h0,
        PLSC_ASPM_L0S = 2'h1,
        PLSC_ASPM_L1 = 2'h2,
        PLSC_ASPM_BOTH = 2'h3
    } plsc_aspm_t;

    ////////////////////////////////////////////////////////////////////////////////
    // slot capability fields
    localparam int ABP_BIT = 0;
    localparam int MRLP_BIT = 2;
    localparam int AIP_BIT = 3;
    localparam int PIP_BIT = 4;
    localparam int HPC_BIT = 6;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask layout
    localparam int IRQ_W = 3;
    localparam int IRQ_TRAIN_DONE = 0;
    localparam int IRQ_TRAIN_ERR = 1;
    localparam int IRQ_WIDTH = 2;

    // strap capture and bus
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

// file: src/plsc_acc_if.sv
// plsc_acc_if: register access strobes between the bus slave and the register bank
// assumes one clock domain; reads are combinational, writes take one cycle
`timescale 1ns/1ps
interface plsc_acc_if;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [31:0] rdata;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wdata;

    modport bus (output rd_en, output rd_addr, input rdata,
                 output wr_en, output wr_addr, output wdata);
    modport regs (input rd_en, input rd_addr, output rdata,
                  input wr_en, input wr_addr, input wdata);
endinterface

// file: src/plsc_ahb_slave.sv
// plsc_ahb_slave: zero-wait AHB-Lite slave front end
// assumes single word transfers; read data sampled in the address phase
`timescale 1ns/1ps
module plsc_ahb_slave (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    plsc_acc_if.bus acc
);

    wire take = hsel && hready && htrans[plsc_pkg::HTRANS_ACTIVE_BIT];
    logic wr_pend;
    logic [7:0] wr_addr;

    // every transfer completes at once with an okay answer
    assign hreadyout = 1'b1;
    assign hresp = plsc_pkg::HRESP_OKAY;

    assign acc.rd_en = take && !hwrite;
    assign acc.rd_addr = haddr[plsc_pkg::ADDR_W-1:0];
    assign acc.wr_en = wr_pend;
    assign acc.wr_addr = wr_addr;
    assign acc.wdata = hwdata;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata <= '0;
        end else begin
            wr_pend <= take && hwrite;
            if (take) begin
                wr_addr <= haddr[plsc_pkg::ADDR_W-1:0];
            end
            if (acc.rd_en) begin
                hrdata <= acc.rdata;
            end
        end
    end

endmodule

// file: bench/plsc_link_model.sv
// plsc_link_model: link training logic feeding the config registers
// assumes the register block samples its link inputs on the rising clock edge
`timescale 1ns/1ps
module plsc_link_model (
    input wire logic clock,
    output logic link_training,
    output logic link_train_error,
    output logic [5:0] link_width
);
    initial begin
        link_training = 1'b0;
        link_train_error = 1'b0;
        link_width = 6'h01;
    end

    // one training run of len cycles, error level set at its start, new width at its end
    task automatic run_training(input logic err, input logic [5:0] w, input int len);
        @(posedge clock);
        link_training <= 1'b1;
        link_train_error <= err;
        repeat (len) @(posedge clock);
        link_training <= 1'b0;
        link_width <= w;
    endtask
endmodule

// file: bench/testbench.sv
// testbench: register checks of the link and slot config block over AHB-Lite
// assumes the block is a zero-wait slave on one 125 MHz clock
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout, hresp, irq;
    logic [31:0] hrdata, lo;
    logic rev_strap = 1'b0;
    logic hp_strap = 1'b0;
    logic link_training, link_train_error;
    logic [5:0] link_width;
    logic [1:0] aspm_control;
    logic link_disable, retrain_link, common_clock, extended_sync;
    logic reverse_mode, hotplug_enabled;
    int fails = 0;
    int tests_run = 0;
    localparam logic [31:0] A_LINK = {24'h0, plsc_pkg::OFS_LINK};
    localparam logic [31:0] A_SLOT = {24'h0, plsc_pkg::OFS_SLOT};
    localparam logic [31:0] A_STAT = {24'h0, plsc_pkg::OFS_IRQ_STAT};
    localparam logic [31:0] A_MASK = {24'h0, plsc_pkg::OFS_IRQ_MASK};
    localparam logic [31:0] STAT_RST = 32'h1011_0000;

    always #4 clock = ~clock;
    assign hready = hreadyout;

    plsc_cfg_regs i_plsc_cfg_regs (.clock(clock), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .reverse_strap(rev_strap), .hotplug_strap(hp_strap), .link_training(link_training),
        .link_train_error(link_train_error), .link_width(link_width),
        .aspm_control(aspm_control), .link_disable(link_disable),
        .retrain_link(retrain_link), .common_clock(common_clock),
        .extended_sync(extended_sync), .reverse_mode(reverse_mode),
        .hotplug_enabled(hotplug_enabled), .irq(irq));

    plsc_link_model i_plsc_link_model (.clock(clock), .link_training(link_training),
        .link_train_error(link_train_error), .link_width(link_width));

    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    // one single transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int n;
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hready !== 1'b1 && n < 100);
        chk("addr_ready", 32'h1, {31'h0, hready});
        htrans <= 2'h0;
        hwdata <= d;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hready !== 1'b1 && n < 100);
        chk("data_ready", 32'h1, {31'h0, hready});
        chk("hresp", 32'h0, {31'h0, hresp});
        rd = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(name, exp, x);
    endtask

    task automatic ctl_chk(input logic [31:0] exp);
        chk("ctl_out", exp & 32'hF3, {24'h0, extended_sync, common_clock, retrain_link,
            link_disable, 2'b00, aspm_control});
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        end_sim;
    end

    initial begin
        for (int i = 1; i < 4; i++) begin
            @(posedge clock);
            reset_n <= 1'b0;
            rev_strap <= i[1];
            hp_strap <= i[0];
            repeat (12) @(posedge clock);
            reset_n <= 1'b1;
            repeat (4) @(posedge clock);
            chk("straps", {30'h0, rev_strap, rev_strap & hp_strap},
                {30'h0, reverse_mode, hotplug_enabled});
            rd_chk("link_rst", A_LINK, STAT_RST);
            ctl_chk(32'h0);
            rd_chk("slot", A_SLOT, (i == 3) ? 32'h5D : 32'h0);
            wr(A_SLOT, 32'hFFFF_FFFF);
            rd_chk("slot_wr", A_SLOT, (i == 3) ? 32'h5D : 32'h0);
            for (int k = 0; k < 4; k++) begin
                wr(A_LINK, k);
                rd_chk("aspm", A_LINK, STAT_RST | k);
                ctl_chk(k);
            end
            lo = i[1] ? 32'hF3 : 32'hC3;
            wr(A_LINK, 32'hFFFF_FFFF);
            rd_chk("link_all", A_LINK, STAT_RST | lo);
            ctl_chk(lo);
            wr(A_LINK, 32'h0);
            rd_chk("link_clr", A_LINK, STAT_RST);
            wr(32'h80, 32'hFFFF_FFFF);
            rd_chk("unmapped", 32'h80, 32'h0);
            $display("test straps %0d done", i);
        end
        wr(A_MASK, 32'h7);
        rd_chk("mask", A_MASK, 32'h7);
        i_plsc_link_model.run_training(1'b1, 6'h02, 5);
        repeat (4) @(posedge clock);
        chk("irq_on", 32'h1, {31'h0, irq});
        rd_chk("stat", A_STAT, 32'h7);
        rd_chk("link_new", A_LINK, 32'h1421_0000);
        wr(A_STAT, 32'h4);
        rd_chk("stat_w1c", A_STAT, 32'h3);
        wr(A_MASK, 32'h0);
        repeat (3) @(posedge clock);
        chk("irq_mask", 32'h0, {31'h0, irq});
        wr(A_STAT, 32'h7);
        rd_chk("stat_clr", A_STAT, 32'h0);
        $display("test interrupts done");
        end_sim;
    end
endmodule
